// ==== rtl/txv_pkg.sv ====
// Package: constants and types of the text-mode video decoder.
// Assumes a single 10 MHz clock domain and 24-bit host byte addresses.
package txv_pkg;
  // ---------------------------------------------------------------
  // Video SRAM windows
  // ---------------------------------------------------------------
  localparam logic [23:0] VRAM_BASE = 24'h0b8000;
  localparam logic [23:0] VRAM_LAST = 24'h0bffff;
  localparam logic [23:0] DATA_LAST = 24'h0bbfff;
  localparam logic [23:0] FONT1_BASE = 24'h0bf800;
  localparam logic [23:0] FONT1_LAST = 24'h0bffff;
  localparam logic [23:0] FONT2_BASE = 24'h0bf000;
  localparam logic [23:0] FONT2_LAST = 24'h0bf7ff;
  localparam logic [23:0] SPEC_BASE = 24'h0bd000;
  localparam logic [23:0] SPEC_LAST = 24'h0bdfff;
  localparam logic [23:0] MONO_BASE = 24'h0be000;
  localparam logic [23:0] MONO_LAST = 24'h0befff;
  localparam int VRAM_BYTES = 32768;
  localparam int GFX2_480_BYTES = 38400;
  localparam int VRAM_AW = 15;
  // ---------------------------------------------------------------
  // Attribute byte and mode port fields
  // ---------------------------------------------------------------
  localparam int ATTR_BLINK_BIT = 7;
  localparam int ATTR_BACK_MSB = 6;
  localparam int ATTR_BACK_LSB = 4;
  localparam int ATTR_BRIGHT_BIT = 3;
  localparam int ATTR_FORE_MSB = 2;
  localparam int ATTR_FORE_LSB = 0;
  localparam int MODE_BLINK_EN_BIT = 5;
  localparam logic [2:0] COLOUR_NONE = 3'h0;
  localparam logic [2:0] COLOUR_ULINE = 3'h1;
  localparam logic [2:0] COLOUR_FULL = 3'h7;
  localparam logic [3:0] MONO_ULINE_ROW = 4'hd;
  localparam logic [2:0] GLYPH_LAST_COL = 3'h7;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic
  {
    colour_text_mode = 1'b0,
    mono_text_mode = 1'b1
  } txv_mode_t;
  typedef enum logic [1:0]
  {
    FONT_8X8_A = 2'b00,
    FONT_8X8_B = 2'b01,
    FONT_8X16 = 2'b10
  } txv_font_t;
  typedef enum logic [2:0]
  {
    S_IDLE = 3'b000,
    S_CHAR = 3'b001,
    S_ATTR = 3'b010,
    S_FONT = 3'b011,
    S_LOAD = 3'b100,
    S_SHIFT = 3'b101
  } txv_state_t;
endpackage

// ==== rtl/txv_font_addr.sv ====
// Font window address generator.
// Assumes code and row are stable while the fetch address is used.
`timescale 1ns/100ps
module txv_font_addr
(
  input wire logic mode,
  input wire logic [1:0] font_sel,
  input wire logic [7:0] glyph_index_code,
  input wire logic [3:0] row,
  output logic [23:0] font_addr
);
  // ---------------------------------------------------------------
  // Offset and base selection
  // ---------------------------------------------------------------
  wire logic [23:0] off8;
  wire logic [23:0] off16;
  wire logic is_mono;
  wire logic is_tall;
  wire logic [23:0] base;
  assign off8 = {13'h0, glyph_index_code, row[2:0]};
  assign off16 = {12'h0, glyph_index_code, row};
  assign is_mono = (mode == txv_pkg::mono_text_mode);
  assign is_tall = is_mono || (font_sel == txv_pkg::FONT_8X16);
  assign base = is_mono ? txv_pkg::MONO_BASE :
                (font_sel == txv_pkg::FONT_8X16) ? txv_pkg::SPEC_BASE :
                (font_sel == txv_pkg::FONT_8X8_B) ? txv_pkg::FONT2_BASE :
                txv_pkg::FONT1_BASE;
  assign font_addr = base + (is_tall ? off16 : off8);
endmodule

// ==== rtl/txv_attr_decode.sv ====
// Attribute byte decoder for colour and monochrome text.
// Assumes blink_en is already taken from the active mode port.
`timescale 1ns/100ps
module txv_attr_decode
(
  input wire logic mode,
  input wire logic blink_en,
  input wire logic [7:0] attr,
  output logic [3:0] fore,
  output logic [3:0] back,
  output logic blink_on,
  output logic uline
);
  // ---------------------------------------------------------------
  // Field split
  // ---------------------------------------------------------------
  wire logic attr_blink;
  wire logic [2:0] attr_back_colour;
  wire logic attr_bright_flag;
  wire logic [2:0] attr_fore_colour;
  wire logic is_mono;
  wire logic m_blank;
  wire logic m_rev;
  wire logic [3:0] c_back;
  wire logic [3:0] m_fore;
  wire logic [3:0] m_back;
  assign attr_blink = attr[txv_pkg::ATTR_BLINK_BIT];
  assign attr_back_colour =
    attr[txv_pkg::ATTR_BACK_MSB:txv_pkg::ATTR_BACK_LSB];
  assign attr_bright_flag = attr[txv_pkg::ATTR_BRIGHT_BIT];
  assign attr_fore_colour =
    attr[txv_pkg::ATTR_FORE_MSB:txv_pkg::ATTR_FORE_LSB];
  assign is_mono = (mode == txv_pkg::mono_text_mode);
  // ---------------------------------------------------------------
  // Colour decode
  // ---------------------------------------------------------------
  // bright background only with blink enabled
  assign c_back = {blink_en & attr_blink, attr_back_colour};
  // ---------------------------------------------------------------
  // Monochrome decode
  // ---------------------------------------------------------------
  assign m_blank = (attr_back_colour == txv_pkg::COLOUR_NONE) &&
                   (attr_fore_colour == txv_pkg::COLOUR_NONE);
  assign m_rev = (attr_back_colour == txv_pkg::COLOUR_FULL) &&
                 (attr_fore_colour == txv_pkg::COLOUR_NONE);
  assign m_fore = (m_blank || m_rev) ? 4'h0 :
                  {attr_bright_flag, txv_pkg::COLOUR_FULL};
  assign m_back = m_rev ? {1'b0, txv_pkg::COLOUR_FULL} : 4'h0;
  assign fore = is_mono ? m_fore : {attr_bright_flag, attr_fore_colour};
  assign back = is_mono ? m_back : c_back;
  assign blink_on = blink_en & attr_blink;
  assign uline = is_mono && (attr_fore_colour == txv_pkg::COLOUR_ULINE) &&
                 (attr_back_colour == txv_pkg::COLOUR_NONE);
endmodule

// ==== rtl/txv_text_decode.sv ====
// Text-mode video memory and character/attribute pixel decoder.
// Assumes all inputs come from logic on clk; host has SRAM priority.
`timescale 1ns/100ps
module txv_text_decode
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic text_mode,
  input wire logic [1:0] font_sel,
  input wire logic [7:0] colour_mode_ctrl,
  input wire logic [7:0] mono_mode_ctrl,
  input wire logic blink_phase,
  input wire logic host_cs,
  input wire logic host_wr,
  input wire logic [23:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  input wire logic fetch_req,
  input wire logic [12:0] fetch_pos,
  input wire logic [3:0] fetch_row,
  output logic fetch_ready,
  output logic pix_valid,
  output logic [3:0] pix_colour,
  input wire logic gfx_panel_480,
  input wire logic gfx_two_bpp_req,
  output logic gfx_two_bpp
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  // glyphs live in this shared array
  logic [7:0] vram [0:txv_pkg::VRAM_BYTES-1];
  txv_pkg::txv_state_t state_q, state_d;
  logic [12:0] pos_q;
  logic [3:0] row_q, pix_colour_q;
  logic [7:0] rd_q, code_q, attr_q, glyph_q, host_rdata_q;
  logic [2:0] col_q;
  logic pix_valid_q;
  wire logic host_hit, grant, disp_rd, blink_en, blink_on, uline;
  wire logic glyph_bit, show_fore, shift_fire, colour_mode, font_rd_c;
  wire logic [23:0] char_addr, attr_addr, font_addr, disp_addr, mem_addr;
  wire logic [14:0] mem_idx;
  wire logic [3:0] fore, back, pix_d;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  assign host_hit = host_cs && (host_addr >= txv_pkg::VRAM_BASE) &&
                    (host_addr <= txv_pkg::VRAM_LAST);
  assign grant = !host_hit;
  // two-byte cells from the data base
  assign char_addr = txv_pkg::VRAM_BASE + {10'h0, pos_q, 1'b0};
  assign attr_addr = txv_pkg::VRAM_BASE + {10'h0, pos_q, 1'b1};
  assign disp_addr = (state_q == txv_pkg::S_CHAR) ? char_addr :
                     (state_q == txv_pkg::S_ATTR) ? attr_addr :
                     font_addr;
  assign disp_rd = (state_q == txv_pkg::S_CHAR) ||
                   (state_q == txv_pkg::S_ATTR) ||
                   (state_q == txv_pkg::S_FONT);
  assign mem_addr = host_hit ? host_addr : disp_addr;
  assign mem_idx = mem_addr[txv_pkg::VRAM_AW-1:0];
  // ---------------------------------------------------------------
  // Font and attribute decoders
  // ---------------------------------------------------------------
  txv_font_addr u_font
  (
    .mode(text_mode),
    .font_sel(font_sel),
    .glyph_index_code(code_q),
    .row(row_q),
    .font_addr(font_addr)
  );
  // blink enable from the active mode port
  assign blink_en = (text_mode == txv_pkg::mono_text_mode) ?
                    mono_mode_ctrl[txv_pkg::MODE_BLINK_EN_BIT] :
                    colour_mode_ctrl[txv_pkg::MODE_BLINK_EN_BIT];
  txv_attr_decode u_attr
  (
    .mode(text_mode),
    .blink_en(blink_en),
    .attr(attr_q),
    .fore(fore),
    .back(back),
    .blink_on(blink_on),
    .uline(uline)
  );
  property p_back_bright;
    colour_mode |-> (back[3] == (blink_en & attr_q[7]));
  endproperty
  a_back_bright: assert property (p_back_bright)
    else $error("background brightness not gated by blink enable");
  // ---------------------------------------------------------------
  // Pixel select
  // ---------------------------------------------------------------
  assign glyph_bit = glyph_q[3'h7 - col_q];
  assign show_fore = (glyph_bit ||
                      (uline && (row_q == txv_pkg::MONO_ULINE_ROW))) &&
                     !(blink_on && !blink_phase);
  assign pix_d = show_fore ? fore : back;
  assign shift_fire = clk_en && (state_q == txv_pkg::S_SHIFT);
  // ---------------------------------------------------------------
  // Graphics depth limit
  // ---------------------------------------------------------------
  // no two bits per pixel on the tall panel
  assign gfx_two_bpp = gfx_two_bpp_req && !gfx_panel_480;
  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      txv_pkg::S_IDLE:
      begin
        if (fetch_req)
        begin
          state_d = txv_pkg::S_CHAR;
        end
      end
      txv_pkg::S_CHAR, txv_pkg::S_ATTR, txv_pkg::S_FONT:
      begin
        if (grant)
        begin
          state_d = txv_pkg::txv_state_t'(state_q + 3'h1);
        end
      end
      txv_pkg::S_LOAD:
      begin
        state_d = txv_pkg::S_SHIFT;
      end
      txv_pkg::S_SHIFT:
      begin
        if (col_q == txv_pkg::GLYPH_LAST_COL)
        begin
          state_d = txv_pkg::S_IDLE;
        end
      end
      default:
      begin
        state_d = txv_pkg::S_IDLE;
      end
    endcase
  end
  assign fetch_ready = (state_q == txv_pkg::S_IDLE);
  // ---------------------------------------------------------------
  // Video SRAM
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (clk_en && host_hit && host_wr)
    begin
      vram[mem_idx] <= host_wdata;
    end
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_q <= 8'h00;
      host_rdata_q <= 8'h00;
    end
    else if (clk_en)
    begin
      if (host_hit && !host_wr)
      begin
        host_rdata_q <= vram[mem_idx];
      end
      if (grant && disp_rd)
      begin
        rd_q <= vram[mem_idx];
      end
    end
  end
  assign host_rdata = host_rdata_q;
  // ---------------------------------------------------------------
  // Fetch registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= txv_pkg::S_IDLE;
      pos_q <= 13'h0000;
      row_q <= 4'h0;
      code_q <= 8'h00;
      attr_q <= 8'h00;
      glyph_q <= 8'h00;
      col_q <= 3'h0;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      if (fetch_ready && fetch_req)
      begin
        pos_q <= fetch_pos;
        row_q <= fetch_row;
      end
      // code captured, then attribute, then glyph
      if ((state_q == txv_pkg::S_ATTR) && grant)
      begin
        code_q <= rd_q;
      end
      if ((state_q == txv_pkg::S_FONT) && grant)
      begin
        attr_q <= rd_q;
      end
      if (state_q == txv_pkg::S_LOAD)
      begin
        glyph_q <= rd_q;
        col_q <= 3'h0;
      end
      else if (state_q == txv_pkg::S_SHIFT)
      begin
        col_q <= col_q + 3'h1;
      end
    end
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pix_valid_q <= 1'b0;
      pix_colour_q <= 4'h0;
    end
    else if (clk_en)
    begin
      pix_valid_q <= shift_fire;
      if (shift_fire)
      begin
        pix_colour_q <= pix_d;
      end
    end
  end
  assign pix_valid = pix_valid_q;
  assign pix_colour = pix_colour_q;
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  assign colour_mode = (text_mode == txv_pkg::colour_text_mode);
  assign font_rd_c = (state_q == txv_pkg::S_FONT) && colour_mode;
  property p_char_even;
    (state_q == txv_pkg::S_CHAR && grant) |->
      (mem_idx[0] == 1'b0 && mem_addr == char_addr);
  endproperty
  a_char_even: assert property (p_char_even)
    else $error("character byte not at even address");
  property p_attr_odd;
    (state_q == txv_pkg::S_ATTR && grant) |->
      (mem_addr == char_addr + 24'h1);
  endproperty
  a_attr_odd: assert property (p_attr_odd)
    else $error("attribute byte not after character byte");
  property p_data_block;
    (disp_rd && state_q != txv_pkg::S_FONT) |->
      (disp_addr <= txv_pkg::DATA_LAST);
  endproperty
  a_data_block: assert property (p_data_block)
    else $error("display data outside 16 KB block");
  property p_font1;
    (font_rd_c && font_sel == txv_pkg::FONT_8X8_A) |->
      (font_addr >= txv_pkg::FONT1_BASE && font_addr <= txv_pkg::FONT1_LAST);
  endproperty
  a_font1: assert property (p_font1)
    else $error("first font fetch outside its window");
  property p_font2;
    (font_rd_c && font_sel == txv_pkg::FONT_8X8_B) |->
      (font_addr >= txv_pkg::FONT2_BASE && font_addr <= txv_pkg::FONT2_LAST);
  endproperty
  a_font2: assert property (p_font2)
    else $error("second font fetch outside its window");
  property p_font_spec;
    (font_rd_c && font_sel == txv_pkg::FONT_8X16) |->
      (font_addr >= txv_pkg::SPEC_BASE && font_addr <= txv_pkg::SPEC_LAST);
  endproperty
  a_font_spec: assert property (p_font_spec)
    else $error("special font fetch outside its window");
  property p_font_mono;
    (state_q == txv_pkg::S_FONT && !colour_mode) |->
      (font_addr >= txv_pkg::MONO_BASE && font_addr <= txv_pkg::MONO_LAST);
  endproperty
  a_font_mono: assert property (p_font_mono)
    else $error("mono font fetch outside its window");
  property p_code_index;
    (state_q == txv_pkg::S_FONT && colour_mode &&
     font_sel != txv_pkg::FONT_8X16) |-> (font_addr[10:3] == code_q);
  endproperty
  a_code_index: assert property (p_code_index)
    else $error("glyph index does not use the full code");
  property p_pix_sel;
    (shift_fire && !uline && !blink_on) |=>
      (pix_valid && pix_colour == ($past(glyph_bit) ? $past(fore) :
                                   $past(back)));
  endproperty
  a_pix_sel: assert property (p_pix_sel)
    else $error("pixel colour not chosen by glyph bit");
  property p_fore_rgb;
    colour_mode |-> (fore == attr_q[3:0]);
  endproperty
  a_fore_rgb: assert property (p_fore_rgb)
    else $error("foreground colour not taken from bits 3 to 0");
  property p_no_2bpp;
    gfx_panel_480 |-> !gfx_two_bpp;
  endproperty
  a_no_2bpp: assert property (p_no_2bpp)
    else $error("two bits per pixel allowed on tall panel");
  sequence s_start;
    fetch_ready && fetch_req && clk_en;
  endsequence
  sequence s_quiet;
    (clk_en && !host_hit) [*5];
  endsequence
  property p_fetch_len;
    (s_start ##1 s_quiet) |-> ##1 pix_valid;
  endproperty
  a_fetch_len: assert property (p_fetch_len)
    else $error("uncontested fetch did not yield a pixel in time");
endmodule

// ==== verif/txv_host_model.sv ====
// Host CPU model: byte writes and reads of the video SRAM port.
// Assumes the decoder samples host signals on the rising clk edge.
`timescale 1ns/100ps
module txv_host_model
(
  input wire logic clk,
  output logic host_cs,
  output logic host_wr,
  output logic [23:0] host_addr,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata
);
  // ------------------------------------------
  // Idle bus
  // ------------------------------------------
  initial
  begin
    host_cs = 1'b0;
    host_wr = 1'b0;
    host_addr = 24'h000000;
    host_wdata = 8'h00;
  end

  // Released bus shows inverted last value
  task automatic drop_bus();
    host_cs = 1'b0;
    host_addr = ~host_addr;
    host_wdata = ~host_wdata;
  endtask

  // ------------------------------------------
  // Byte accesses
  // ------------------------------------------
  // byte wide cells
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    host_cs = 1'b1;
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    @(posedge clk);
    #1;
    drop_bus();
  endtask

  task automatic rd(input logic [23:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    host_cs = 1'b1;
    host_wr = 1'b0;
    host_addr = a;
    @(posedge clk);
    #1;
    d = host_rdata;
    drop_bus();
  endtask
endmodule

// ==== verif/txv_text_decode_tb_top.sv ====
// Testbench: text decoder driven through the host model and fetch port.
// Assumes one 10 MHz clock and the host model on the SRAM port.
`timescale 1ns/100ps
module txv_text_decode_tb_top;
  // ------------------------------------------
  // Signals
  // ------------------------------------------
  logic clk, arst_n, clk_en, text_mode, blink_phase, fetch_req;
  logic host_cs, host_wr, fetch_ready, pix_valid;
  logic gfx_panel_480, gfx_two_bpp_req, gfx_two_bpp;
  logic [1:0] font_sel;
  logic [7:0] colour_mode_ctrl, mono_mode_ctrl, host_wdata, host_rdata;
  logic [23:0] host_addr;
  logic [12:0] fetch_pos;
  logic [3:0] fetch_row, pix_colour;
  int fails = 0;
  int compares = 0;

  txv_text_decode uut (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .text_mode(text_mode), .font_sel(font_sel),
    .colour_mode_ctrl(colour_mode_ctrl), .mono_mode_ctrl(mono_mode_ctrl),
    .blink_phase(blink_phase), .host_cs(host_cs), .host_wr(host_wr),
    .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .fetch_req(fetch_req), .fetch_pos(fetch_pos),
    .fetch_row(fetch_row), .fetch_ready(fetch_ready),
    .pix_valid(pix_valid), .pix_colour(pix_colour),
    .gfx_panel_480(gfx_panel_480), .gfx_two_bpp_req(gfx_two_bpp_req),
    .gfx_two_bpp(gfx_two_bpp));

  txv_host_model host (.clk(clk), .host_cs(host_cs), .host_wr(host_wr),
    .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ------------------------------------------
  // Helpers
  // ------------------------------------------
  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic [23:0] gaddr(input logic [7:0] c,
    input logic [3:0] r);
    if (text_mode)
      return txv_pkg::MONO_BASE + {12'h000, c, r};
    if (font_sel == 2'b10)
      return txv_pkg::SPEC_BASE + {12'h000, c, r};
    if (font_sel == 2'b01)
      return txv_pkg::FONT2_BASE + {13'h0000, c, r[2:0]};
    return txv_pkg::FONT1_BASE + {13'h0000, c, r[2:0]};
  endfunction

  function automatic logic [3:0] exp_pix(input logic [7:0] a,
    input logic b, input logic u);
    logic be;
    logic [3:0] f;
    logic [3:0] k;
    be = text_mode ? mono_mode_ctrl[5] : colour_mode_ctrl[5];
    f = a[3:0];
    k = {be & a[7], a[6:4]};
    if (text_mode)
    begin
      f = (a[2:0] == 3'h0 && (a[6:4] == 3'h0 || a[6:4] == 3'h7)) ?
        4'h0 : {a[3], 3'h7};
      k = (a[6:4] == 3'h7 && a[2:0] == 3'h0) ? 4'h7 : 4'h0;
    end
    return ((b || u) && !(be && a[7] && !blink_phase)) ? f : k;
  endfunction

  task automatic put_cell(input logic [12:0] p, input logic [7:0] code,
    input logic [7:0] attr);
    host.wr(txv_pkg::VRAM_BASE + {10'h000, p, 1'b0}, code);
    host.wr(txv_pkg::VRAM_BASE + {10'h000, p, 1'b1}, attr);
  endtask

  task automatic run_cell(input logic [12:0] p, input logic [3:0] row,
    input logic [7:0] attr, input logic [7:0] glyph);
    int n;
    int k;
    logic u;
    n = 0;
    k = 0;
    u = text_mode && (row == txv_pkg::MONO_ULINE_ROW) &&
      (attr[6:4] == 3'h0) && (attr[2:0] == 3'h1);
    while (fetch_ready !== 1'b1 && k < 50)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    fetch_pos = p;
    fetch_row = row;
    fetch_req = 1'b1;
    @(posedge clk);
    #1;
    fetch_req = 1'b0;
    check("ready after take", {7'h00, fetch_ready}, 8'h00);
    while (n < 8 && k < 100)
    begin
      if (pix_valid === 1'b1)
      begin
        check("pixel", {4'h0, pix_colour},
          {4'h0, exp_pix(attr, glyph[7 - n], u)});
        n++;
      end
      @(posedge clk);
      #1;
      k++;
    end
    check("pixel count", 8'(n), 8'h08);
    check("ready after row", {7'h00, fetch_ready}, 8'h01);
  endtask

  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  task automatic t_sram();
    logic [7:0] d;
    host.wr(24'h0b8005, 8'ha5);
    host.wr(24'h0c0005, 8'h5a);
    host.rd(24'h0b8005, d);
    check("sram outside window", d, 8'ha5);
    clk_en = 1'b0;
    host.wr(24'h0b8005, 8'h77);
    clk_en = 1'b1;
    host.rd(24'h0b8005, d);
    check("frozen write", d, 8'ha5);
    host.wr(24'h0bffff, 8'h3c);
    host.rd(24'h0bffff, d);
    check("sram top byte", d, 8'h3c);
    $display("t_sram done");
  endtask

  task automatic t_fonts();
    text_mode = 1'b0;
    put_cell(13'h0000, 8'hff, 8'h1e);
    for (int f = 0; f < 3; f++)
    begin
      font_sel = f[1:0];
      host.wr(gaddr(8'hff, 4'h7), 8'h81 + 8'h11 * f[7:0]);
    end
    for (int f = 0; f < 3; f++)
    begin
      font_sel = f[1:0];
      run_cell(13'h0000, 4'h7, 8'h1e, 8'h81 + 8'h11 * f[7:0]);
    end
    text_mode = 1'b1;
    put_cell(13'h0000, 8'hff, 8'h07);
    host.wr(gaddr(8'hff, 4'h5), 8'hc3);
    run_cell(13'h0000, 4'h5, 8'h07, 8'hc3);
    text_mode = 1'b0;
    font_sel = 2'b00;
    put_cell(13'h1fff, 8'h00, 8'h4a);
    host.wr(gaddr(8'h00, 4'h0), 8'h35);
    run_cell(13'h1fff, 4'h0, 8'h4a, 8'h35);
    $display("t_fonts done");
  endtask

  task automatic t_colours();
    text_mode = 1'b0;
    font_sel = 2'b10;
    for (int e = 0; e < 2; e++)
    begin
      colour_mode_ctrl = e[0] ? 8'h20 : 8'h00;
      for (int i = 0; i < 8; i++)
      begin
        put_cell(13'(i + 3), 8'h20 + i[7:0], 8'h29 * i[7:0]);
        host.wr(gaddr(8'h20 + i[7:0], 4'h3), 8'h96);
        run_cell(13'(i + 3), 4'h3, 8'h29 * i[7:0], 8'h96);
      end
    end
    $display("t_colours done");
  endtask

  task automatic t_blink();
    text_mode = 1'b0;
    font_sel = 2'b01;
    put_cell(13'h0040, 8'h41, 8'hc9);
    host.wr(gaddr(8'h41, 4'h2), 8'h5a);
    colour_mode_ctrl = 8'h20;
    blink_phase = 1'b0;
    run_cell(13'h0040, 4'h2, 8'hc9, 8'h5a);
    colour_mode_ctrl = 8'h00;
    mono_mode_ctrl = 8'h20;
    run_cell(13'h0040, 4'h2, 8'hc9, 8'h5a);
    text_mode = 1'b1;
    put_cell(13'h0040, 8'h41, 8'h87);
    host.wr(gaddr(8'h41, 4'h2), 8'h6c);
    run_cell(13'h0040, 4'h2, 8'h87, 8'h6c);
    mono_mode_ctrl = 8'h00;
    run_cell(13'h0040, 4'h2, 8'h87, 8'h6c);
    blink_phase = 1'b1;
    $display("t_blink done");
  endtask

  task automatic t_mono();
    logic [7:0] a;
    text_mode = 1'b1;
    host.wr(gaddr(8'h55, txv_pkg::MONO_ULINE_ROW), 8'h0f);
    for (int i = 0; i < 3; i++)
    begin
      a = (i == 0) ? 8'h09 : (i == 1) ? 8'h70 : 8'h00;
      put_cell(13'h0050, 8'h55, a);
      run_cell(13'h0050, txv_pkg::MONO_ULINE_ROW, a, 8'h0f);
    end
    $display("t_mono done");
  endtask

  task automatic t_gfx();
    for (int i = 0; i < 4; i++)
    begin
      gfx_panel_480 = i[1];
      gfx_two_bpp_req = i[0];
      #1;
      check("two bpp", {7'h00, gfx_two_bpp}, {7'h00, i == 1});
    end
    $display("t_gfx done");
  endtask

  // ------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------
  initial
  begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    text_mode = 1'b0;
    font_sel = 2'b00;
    colour_mode_ctrl = 8'h00;
    mono_mode_ctrl = 8'h00;
    blink_phase = 1'b1;
    fetch_req = 1'b0;
    fetch_pos = 13'h0000;
    fetch_row = 4'h0;
    gfx_panel_480 = 1'b0;
    gfx_two_bpp_req = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    arst_n = 1'b1;
    t_sram();
    t_fonts();
    t_colours();
    t_blink();
    t_mono();
    t_gfx();
    stop_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test();
  end
endmodule
